//--- src/iec_expander.sv
/*
 Eight-input expander with latched change detection, served as a serial
 two-wire slave; SCL and SDA are oversampled by clk_i.
 Assumes clk_i at least eight times the SCL rate and external pull-ups.
*/
// Behaviour
// RULE1 - long reads alternate input byte and flags
// RULE2 - resample and clear flags each byte pair
// RULE3 - eight-bit alert mask, one bit per input
// RULE4 - flags set on change regardless of mask
// RULE5 - no alert during reads; defer to STOP
// RULE6 - no alert for changes already read out
// RULE7 - flag stays set until next access
// RULE8 - mask gates alert only, never the flag
// RULE9 - SDA open-drain in/out, SCL input only
// RULE10 - master frames with START and STOP; detect both
// RULE11 - SDA stable while SCL high, bit per pulse
// RULE12 - device acknowledges received bytes low
// RULE13 - master acknowledges bytes the device sends
// RULE14 - first byte: seven address bits plus direction
// RULE15 - address 110 plus two four-level straps
// RULE16 - one-byte read gives inputs, clears flags, alert
// RULE17 - clear at address ack; send old flags
// RULE18 - inputs captured at ack before input byte
// RULE19 - one-byte write loads mask, clears flags, alert
// RULE20 - each written byte replaces the mask
// RULE21 - snapshot compared with live inputs continuously
// RULE22 - mask one enables; alert on enabled flag
// RULE23 - reset: flags clear, snapshot live, alert off
`timescale 1ns/1ps
`include "iec_regs.svh"
module iec_expander (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_b_o,
	input  wire logic       addr_strap_low_i,
	input  wire logic       addr_strap_high_i,
	input  wire logic [7:0] port_i,
	output logic            alert_b_o
);
	import iec_pkg::*;

	logic [11:0] sync_bus;
	logic [7:0]  port_s;
	iec_line_s   line_now;
	iec_line_s   line_reg;
	iec_evt_s    evt;
	iec_strap_e  strap_lo_cls;
	iec_strap_e  strap_hi_cls;
	logic [6:0]  own_addr;
	logic [2:0]  settle_reg;
	logic [2:0]  settle_next;
	logic        settled;
	iec_state_e  state_reg;
	iec_state_e  state_next;
	logic [2:0]  bit_reg;
	logic [2:0]  bit_next;
	logic [7:0]  shift_reg;
	logic [7:0]  shift_next;
	logic        drive_reg;
	logic        drive_next;
	logic        rw_reg;
	logic        rw_next;
	logic        odd_reg;
	logic        odd_next;
	logic [7:0]  mask_reg;
	logic [7:0]  mask_next;
	logic        resample;
	logic [7:0]  next_byte;
	logic [7:0]  snap_reg;
	logic [7:0]  snap_next;
	logic [7:0]  flags_reg;
	logic [7:0]  flags_next;
	logic [7:0]  saved_reg;
	logic [7:0]  saved_next;
	logic [7:0]  diff;
	logic        read_busy;
	logic        alert_reg;
	logic        alert_next;
	// Address bits that one strap contributes
	function automatic logic [1:0] strap_bits(input iec_strap_e cls, input logic high);
		logic [1:0] b;
		b = 2'h0;
		unique case (cls)
			STRAP_GND: b = high ? 2'h2 : 2'h0;
			STRAP_SUP: b = high ? 2'h3 : 2'h1;
			STRAP_SCL: b = high ? 2'h0 : 2'h2;
			STRAP_SDA: b = high ? 2'h1 : 2'h3;
		endcase
		return b;
	endfunction

	// Strap, bus and port pins cross into clk_i through one synchroniser bank; rst_b_i does not
	iec_sync #(
		.WIDTH (12)
	) u_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.async_i ({addr_strap_high_i, addr_strap_low_i, scl_i, sda_i, port_i}),
		.sync_o  (sync_bus)
	);

	assign port_s       = sync_bus[7:0];
	assign line_now.sda = sync_bus[8];
	assign line_now.scl = sync_bus[9]; // RULE9

	iec_strap u_strap_lo (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.en_i    (settled),
		.strap_i (sync_bus[10]),
		.line_i  (line_now),
		.class_o (strap_lo_cls)
	);

	iec_strap u_strap_hi (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.en_i    (settled),
		.strap_i (sync_bus[11]),
		.line_i  (line_now),
		.class_o (strap_hi_cls)
	);

	// Slave address from fixed top bits and the two straps
	assign own_addr = {`IEC_ADDR_TOP, strap_bits(strap_hi_cls, 1'b1), strap_bits(strap_lo_cls, 1'b0)}; // RULE15

	// Edge and condition detection on the synced lines
	always_comb begin
		evt.scl_rise = line_now.scl & ~line_reg.scl;
		evt.scl_fall = ~line_now.scl & line_reg.scl;
		evt.start    = line_reg.scl & line_now.scl & line_reg.sda & ~line_now.sda; // RULE10
		evt.stop     = line_reg.scl & line_now.scl & ~line_reg.sda & line_now.sda; // RULE10
	end

	// Settle counter; synced inputs are zero until the pipeline fills
	always_comb begin
		settled     = (settle_reg == `IEC_SETTLE_CYC);
		settle_next = settled ? settle_reg : settle_reg + 3'h1;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			line_reg   <= '{scl: 1'b1, sda: 1'b1};
			settle_reg <= 3'h0;
		end else begin
			line_reg   <= line_now;
			settle_reg <= settle_next;
		end
	end

	// Byte to send after the current one: inputs after flags, else flags
	assign next_byte = odd_reg ? snap_reg : saved_reg; // RULE1

	// Protocol engine: sample on SCL rise, change SDA on SCL fall
	always_comb begin
		state_next = state_reg;
		bit_next   = bit_reg;
		shift_next = shift_reg;
		drive_next = drive_reg;
		rw_next    = rw_reg;
		odd_next   = odd_reg;
		mask_next  = mask_reg;
		resample   = 1'b0;
		if (evt.start) begin
			state_next = ST_ADDR;
			bit_next   = 3'h0;
			drive_next = 1'b0;
			rw_next    = 1'b0;
		end else if (evt.stop) begin
			state_next = ST_IDLE;
			drive_next = 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE, ST_WAIT: drive_next = 1'b0;
				ST_ADDR: begin
					if (evt.scl_rise) begin
						shift_next = {shift_reg[6:0], line_now.sda}; // RULE11
						bit_next   = bit_reg + 3'h1;
						if (bit_reg == `IEC_BIT_LAST)
							state_next = ST_ADDR_END;
					end
				end
				ST_ADDR_END: begin
					if (evt.scl_fall) begin
						if (shift_reg[7:1] == own_addr) begin // RULE14
							drive_next = 1'b1; // RULE12
							rw_next    = shift_reg[`IEC_RW_BIT];
							resample   = 1'b1; // RULE18
							state_next = ST_ADDR_ACK;
						end else begin
							state_next = ST_WAIT;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (evt.scl_fall) begin
						bit_next = 3'h0;
						if (rw_reg == `IEC_RW_READ) begin
							shift_next = snap_reg; // RULE16
							odd_next   = 1'b0;
							drive_next = ~snap_reg[7];
							state_next = ST_RD_DATA;
						end else begin
							drive_next = 1'b0;
							state_next = ST_WR_DATA;
						end
					end
				end
				ST_WR_DATA: begin
					if (evt.scl_rise) begin
						shift_next = {shift_reg[6:0], line_now.sda}; // RULE11
						bit_next   = bit_reg + 3'h1;
						if (bit_reg == `IEC_BIT_LAST)
							state_next = ST_WR_END;
					end
				end
				ST_WR_END: begin
					if (evt.scl_fall) begin
						mask_next  = shift_reg; // RULE19 RULE20
						drive_next = 1'b1; // RULE12
						state_next = ST_WR_ACK;
					end
				end
				ST_WR_ACK: begin
					if (evt.scl_fall) begin
						drive_next = 1'b0;
						bit_next   = 3'h0;
						state_next = ST_WR_DATA;
					end
				end
				ST_RD_DATA: begin
					if (evt.scl_fall) begin
						shift_next = {shift_reg[6:0], 1'b0};
						bit_next   = bit_reg + 3'h1;
						if (bit_reg == `IEC_BIT_LAST) begin
							drive_next = 1'b0;
							state_next = ST_RD_ACK;
						end else begin
							drive_next = ~shift_reg[6]; // RULE11
						end
					end
				end
				ST_RD_ACK: begin
					if (evt.scl_rise) begin
						if (line_now.sda) begin
							state_next = ST_WAIT; // RULE13
						end else begin
							resample   = odd_reg; // RULE2 RULE18
							state_next = ST_RD_NEXT;
						end
					end
				end
				ST_RD_NEXT: begin
					if (evt.scl_fall) begin
						shift_next = next_byte; // RULE1 RULE17
						odd_next   = ~odd_reg;
						drive_next = ~next_byte[7];
						bit_next   = 3'h0;
						state_next = ST_RD_DATA;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_IDLE;
			bit_reg   <= 3'h0;
			shift_reg <= 8'h00;
			drive_reg <= 1'b0;
			rw_reg    <= 1'b0;
			odd_reg   <= 1'b0;
			mask_reg  <= `IEC_MASK_RST;
		end else begin
			state_reg <= state_next;
			bit_reg   <= bit_next;
			shift_reg <= shift_next;
			drive_reg <= drive_next;
			rw_reg    <= rw_next;
			odd_reg   <= odd_next;
			mask_reg  <= mask_next; // RULE3
		end
	end

	// Snapshot and flags; a change in the clearing cycle lands in the saved copy, never lost
	always_comb begin
		diff       = port_s ^ snap_reg; // RULE21
		snap_next  = snap_reg;
		saved_next = saved_reg;
		flags_next = flags_reg | diff; // RULE4 RULE7
		if (!settled) begin
			snap_next  = port_s; // RULE23
			flags_next = 8'h00;
			saved_next = 8'h00;
		end else if (resample) begin
			snap_next  = port_s; // RULE18
			saved_next = flags_reg | diff; // RULE17
			flags_next = 8'h00; // RULE16 RULE19
		end
	end

	// Alert: cleared at each capture, frozen through a read, so a late change rises only at STOP
	always_comb begin
		read_busy = (rw_reg == `IEC_RW_READ) && (state_reg inside {ST_ADDR_ACK, ST_RD_DATA, ST_RD_ACK,
			ST_RD_NEXT, ST_WAIT});
		if (resample || !settled)
			alert_next = 1'b0; // RULE16 RULE23
		else if (read_busy)
			alert_next = alert_reg; // RULE5
		else
			alert_next = |(flags_reg & mask_reg); // RULE6 RULE8 RULE22
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			snap_reg  <= 8'h00;
			flags_reg <= 8'h00;
			saved_reg <= 8'h00;
			alert_reg <= 1'b0;
		end else begin
			snap_reg  <= snap_next;
			flags_reg <= flags_next;
			saved_reg <= saved_next;
			alert_reg <= alert_next;
		end
	end

	// Open drain: only ever pull low, enable is active low
	assign sda_o      = 1'b0; // RULE9
	assign sda_oe_b_o = ~drive_reg;
	assign alert_b_o  = ~alert_reg;
endmodule

//--- src/iec_pkg.sv
/*
 Types shared by the input expander modules.
 Assumes iec_regs.svh sits beside it for the constants.
*/
package iec_pkg;

	// Four-level strap connection
	typedef enum logic [1:0] {
		STRAP_GND,
		STRAP_SUP,
		STRAP_SDA,
		STRAP_SCL
	} iec_strap_e;

	// Serial protocol states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_END,
		ST_ADDR_ACK,
		ST_WR_DATA,
		ST_WR_END,
		ST_WR_ACK,
		ST_RD_DATA,
		ST_RD_ACK,
		ST_RD_NEXT,
		ST_WAIT
	} iec_state_e;

	// Synced serial line levels
	typedef struct packed {
		logic scl;
		logic sda;
	} iec_line_s;

	// Bus events seen in one clock cycle
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} iec_evt_s;

endpackage

//--- src/iec_regs.svh
/*
 Constants of the input expander: slave address layout, reset values and
 small counts. Assumes inclusion by the package and the modules only.
*/
`ifndef IEC_REGS_SVH
`define IEC_REGS_SVH

// Fixed top three slave address bits
`define IEC_ADDR_TOP      3'h6
// Position of the direction bit in the first byte
`define IEC_RW_BIT        0
// Direction bit value that requests a read
`define IEC_RW_READ       1'h1
// Last bit index within a byte
`define IEC_BIT_LAST      3'h7
// Reset value of the change alert mask
`define IEC_MASK_RST      8'h00
// Cycles after reset before the synced inputs are trusted
`define IEC_SETTLE_CYC    3'h5

`endif

//--- src/iec_strap.sv
/*
 Four-level strap classifier: ground, supply, SDA or SCL.
 Assumes synced strap and bus levels of equal latency; en_i rises once
 the synchronisers have settled.
*/
`timescale 1ns/1ps
module iec_strap (
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              en_i,
	input  wire logic              strap_i,
	input  iec_pkg::iec_line_s     line_i,
	output iec_pkg::iec_strap_e    class_o
);
	import iec_pkg::*;

	logic       seen_low_reg;
	logic       seen_low_next;
	logic       neq_sda_reg;
	logic       neq_sda_next;
	logic       neq_scl_reg;
	logic       neq_scl_next;
	iec_strap_e class_reg;
	iec_strap_e class_next;

	// Sticky evidence; a strap tied to a bus line looks like supply until
	// that line first goes low, which is harmless before any transfer
	always_comb begin
		seen_low_next = seen_low_reg | (en_i & ~strap_i);
		neq_sda_next  = neq_sda_reg | (en_i & (strap_i ^ line_i.sda));
		neq_scl_next  = neq_scl_reg | (en_i & (strap_i ^ line_i.scl));
		if (!seen_low_reg)
			class_next = STRAP_SUP;
		else if (!neq_scl_reg)
			class_next = STRAP_SCL;
		else if (!neq_sda_reg)
			class_next = STRAP_SDA;
		else
			class_next = STRAP_GND;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seen_low_reg <= 1'b0;
			neq_sda_reg  <= 1'b0;
			neq_scl_reg  <= 1'b0;
			class_reg    <= STRAP_SUP;
		end else begin
			seen_low_reg <= seen_low_next;
			neq_sda_reg  <= neq_sda_next;
			neq_scl_reg  <= neq_scl_next;
			class_reg    <= class_next;
		end
	end

	assign class_o = class_reg;
endmodule

//--- src/iec_sync.sv
/*
 Three-stage input synchroniser with agreement filter.
 Assumes inputs asynchronous to clk_i; output changes once stages two and
 three agree.
*/
`timescale 1ns/1ps
module iec_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] out_reg;
	logic [WIDTH-1:0] out_next;

	// Take the agreed level, else hold; stage one feeds stage two only
	always_comb begin
		out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			out_reg <= '0;
		end else begin
			s1_reg  <= async_i;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign sync_o = out_reg;
endmodule

//--- verif/iec_expander_properties.sv
/*
 Checker for the input expander pins.
 Assumes binding to iec_expander; sees only that module's ports.
*/
`timescale 1ns/1ps
module iec_expander_properties (
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_b_o,
	input wire logic       addr_strap_low_i,
	input wire logic       addr_strap_high_i,
	input wire logic [7:0] port_i,
	input wire logic       alert_b_o
);
	logic       scl_reg;
	logic       sda_reg;
	logic       rw_reg;
	logic       rd_reg;
	logic [7:0] bit_reg;
	logic [7:0] port_reg;
	logic [4:0] cause_reg;
	logic [4:0] fall_reg;
	wire        start_w = scl_i & scl_reg & sda_reg & ~sda_i;
	wire        stop_w  = scl_i & scl_reg & ~sda_reg & sda_i;
	wire        rise_w  = scl_i & ~scl_reg;
	wire        fall_w  = ~scl_i & scl_reg;

	// Pin-level tracker; read phase held from acked read address to STOP
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			rw_reg <= 1'b0;
			rd_reg <= 1'b0;
			bit_reg <= 8'h00;
			port_reg <= 8'h00;
			cause_reg <= 5'h1F;
			fall_reg <= 5'h1F;
		end else begin
			scl_reg <= scl_i;
			sda_reg <= sda_i;
			port_reg <= port_i;
			if (start_w) bit_reg <= 8'h00;
			else if (rise_w && bit_reg != 8'hFF) bit_reg <= bit_reg + 8'h01;
			if (rise_w && bit_reg == 8'h07) rw_reg <= sda_i;
			if (stop_w) rd_reg <= 1'b0;
			else if (rise_w && bit_reg == 8'h08 && rw_reg && !sda_oe_b_o) rd_reg <= 1'b1;
			// Saturating ages; a cause too old cannot explain an alert
			if (port_i != port_reg || stop_w || fall_w) cause_reg <= 5'h00;
			else if (cause_reg != 5'h1F) cause_reg <= cause_reg + 5'h01;
			if (fall_w) fall_reg <= 5'h00;
			else if (fall_reg != 5'h1F) fall_reg <= fall_reg + 5'h01;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_quiet;
		sda_oe_b_o && alert_b_o;
	endsequence
	sequence s_released;
		sda_oe_b_o [*6];
	endsequence

	a_rst_quiet: assert property ($rose(rst_b_i) |-> s_quiet [*4])
		else $error("outputs active right after reset");
	a_data_zero: assert property (sda_o == 1'b0)
		else $error("data pin value not open drain");
	a_oe_scl_low: assert property ($changed(sda_oe_b_o) |-> !$past(scl_i, 2))
		else $error("data drive changed late in clock high");
	a_oe_after_fall: assert property ($changed(sda_oe_b_o) |-> fall_reg < 5'd9)
		else $error("data drive changed away from clock fall");
	a_start_idle: assert property (start_w |=> s_released)
		else $error("data driven right after start");
	a_stop_release: assert property (stop_w |=> s_released)
		else $error("data driven right after stop");
	a_alert_rise_low: assert property ($rose(alert_b_o) |-> !scl_i)
		else $error("alert cleared outside an acknowledge");
	a_alert_cause: assert property ($fell(alert_b_o) |-> cause_reg < 5'd16)
		else $error("alert raised with no recent cause");
	a_no_alert_read: assert property (rd_reg |-> !$fell(alert_b_o))
		else $error("alert raised during a read");
endmodule

bind iec_expander iec_expander_properties u_props (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_b_o(sda_oe_b_o), .addr_strap_low_i(addr_strap_low_i),
	.addr_strap_high_i(addr_strap_high_i), .port_i(port_i), .alert_b_o(alert_b_o));

//--- verif/iec_master_model.sv
/*
 Behavioural two-wire bus master, 12 clocks per bit.
 Assumes the bench resolves SDA with a pull-up and feeds it back.
*/
`timescale 1ns/1ps
module iec_master_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_b_o
);
	// Bus idles released and high
	initial begin
		scl_o = 1'b1;
		sda_oe_b_o = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Data moves only mid-low, sampled mid-high
	task automatic xbit(input logic b, output logic r);
		scl_o <= 1'b0;
		tick(3);
		sda_oe_b_o <= b;
		tick(3);
		scl_o <= 1'b1;
		tick(3);
		r = sda_i;
		tick(3);
	endtask

	task automatic start();
		sda_oe_b_o <= 1'b0;
		tick(6);
	endtask

	task automatic stop();
		scl_o <= 1'b0;
		tick(3);
		sda_oe_b_o <= 1'b0;
		tick(3);
		scl_o <= 1'b1;
		tick(3);
		sda_oe_b_o <= 1'b1;
		tick(6);
	endtask

	// Address or data out, MSB first, ninth bit left to the slave
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xbit(d[i], r);
		xbit(1'b1, ack);
	endtask

	// Byte in; master answers ack, or no-ack on the last byte
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
		xbit(last, r);
	endtask
endmodule

//--- verif/tb.sv
/*
 Self-checking bench for the input expander.
 Assumes the master model and the bound checker compile first.
*/
`timescale 1ns/1ps
module tb;
	localparam logic [6:0] ADDR = 7'h69; // High strap ground, low strap supply
	logic       clk_i;
	logic       rst_b_i;
	logic       m_scl;
	logic       m_oe_b;
	logic       sda_o;
	logic       sda_oe_b_o;
	logic       alert_b_o;
	logic       a;
	logic [7:0] port_i;
	logic [7:0] got;
	logic [7:0] b;
	logic [7:0] d;
	logic [7:0] exp_q[$];
	int         n_mismatch;
	int         cmp_count;
	int         seed;
	event       res_ev;
	wire        sda = m_oe_b & (sda_oe_b_o | sda_o); // Pull-up wired AND

	iec_expander DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(m_scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_b_o(sda_oe_b_o), .addr_strap_low_i(1'b1), .addr_strap_high_i(1'b0),
		.port_i(port_i), .alert_b_o(alert_b_o));
	iec_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(m_scl), .sda_oe_b_o(m_oe_b));

	always #2 clk_i = ~clk_i;

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Note the expectation, hand the observation over, realign to an edge
	task automatic post(input logic [7:0] e, input logic [7:0] g);
		exp_q.push_back(e);
		got = g;
		->res_ev;
		@(posedge clk_i);
	endtask

	task automatic alert_is(input logic e);
		repeat (20) @(posedge clk_i);
		post({7'h00, e}, {7'h00, alert_b_o});
	endtask

	task automatic flip(input logic [7:0] x);
		port_i <= port_i ^ x;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] v);
		m.start();
		m.wbyte({ADDR, 1'b0}, a);
		post(8'h00, {7'h00, a});
		m.wbyte(v, a);
		post(8'h00, {7'h00, a});
		m.stop();
	endtask

	// Two mask bytes in one transfer; the second must stand
	task automatic wr2(input logic [7:0] v0, input logic [7:0] v1);
		m.start();
		m.wbyte({ADDR, 1'b0}, a);
		post(8'h00, {7'h00, a});
		m.wbyte(v0, a);
		post(8'h00, {7'h00, a});
		m.wbyte(v1, a);
		post(8'h00, {7'h00, a});
		m.stop();
	endtask

	task automatic rd_addr();
		m.start();
		m.wbyte({ADDR, 1'b1}, a);
		post(8'h00, {7'h00, a});
	endtask

	// Monitor: oldest note against each observation
	initial forever begin
		@(res_ev);
		cmp_count++;
		if (got !== exp_q[0]) begin
			n_mismatch++;
			$display("mismatch at %0t: expected %h got %h", $time, exp_q[0], got);
		end
		void'(exp_q.pop_front());
	end

	// Hang guard; the sequence needs about 3600 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		complete_run();
	end

	initial begin
		seed = 54;
		clk_i = 1'b0;
		rst_b_i = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		port_i = 8'($random(seed));
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		alert_is(1'b1);
		m.start();
		m.wbyte({ADDR ^ 7'h01, 1'b0}, a);
		post(8'h01, {7'h00, a});
		m.stop();
		// Flags must read clear straight after reset, whatever the inputs
		rd_addr();
		m.rbyte(1'b0, b);
		post(port_i, b);
		m.rbyte(1'b1, b);
		post(8'h00, b);
		m.stop();
		wr(8'hFF);
		d = 8'($random(seed)) | 8'h01;
		flip(d);
		alert_is(1'b0);
		wr(8'h00);
		alert_is(1'b1);
		// Pulse an input and return it with the mask clear; the flag must survive, the alert stay off
		d = 8'($random(seed)) | 8'h01;
		flip(d);
		alert_is(1'b1);
		flip(d);
		rd_addr();
		m.rbyte(1'b0, b);
		post(port_i, b);
		m.rbyte(1'b1, b);
		post(d, b);
		m.stop();
		alert_is(1'b1);
		// Long read with a change that is read out before STOP
		wr(8'hFF);
		rd_addr();
		m.rbyte(1'b0, b);
		post(port_i, b);
		d = 8'($random(seed)) | 8'h01;
		flip(d);
		m.rbyte(1'b0, b);
		post(8'h00, b);
		post(8'h01, {7'h00, alert_b_o});
		m.rbyte(1'b0, b);
		post(port_i, b);
		m.rbyte(1'b1, b);
		post(d, b);
		m.stop();
		alert_is(1'b1);
		// Change after capture stays unread: alert deferred to STOP
		rd_addr();
		m.rbyte(1'b0, b);
		post(port_i, b);
		flip(8'($random(seed)) | 8'h01);
		m.rbyte(1'b1, b);
		post(8'h00, b);
		m.stop();
		alert_is(1'b0);
		rd_addr();
		m.rbyte(1'b1, b);
		post(port_i, b);
		m.stop();
		alert_is(1'b1);
		// Two mask bytes in one write: only the second may decide the alert
		wr2(8'hFF, 8'h00);
		flip(8'($random(seed)) | 8'h01);
		alert_is(1'b1);
		wr2(8'h00, 8'hFF);
		flip(8'($random(seed)) | 8'h01);
		alert_is(1'b0);
		complete_run();
	end
endmodule
